// ===== hw/acmsd_decode.sv
// decoder and executor for multiply/shift memory ops and constant ops
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "acmsd_cfg.svh"
module acmsd_decode (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic instr_valid,
	input wire logic [16:0] instr_word,
	output logic instr_ready,
	input wire logic [15:0] mem_operand,
	output logic pm_rd,
	output logic [15:0] pm_addr,
	input wire logic [15:0] pm_rdata
);
	import acmsd_pkg::*;

	acmsd_state_t st_q;
	logic [15:0] acc_q [0:7];
	logic [15:0] multiplier_operand_reg_q;
	logic [15:0] product_high_reg_q;
	logic [3:0] shift_value_reg_q;
	logic sign_extend_mode_q;
	logic unsigned_multiply_mode_q;
	logic string_mode_q;
	logic [7:0] string_count_q;
	acmsd_flags_t flags_q;
	logic [16:0] op_word_q;
	logic [7:0] str_left_q;
	logic [1:0] str_k_q;
	logic [15:0] pm_addr_q;
	logic [31:0] prdata_q;

	logic take;
	logic take_op;
	logic take_k;
	logic is_short;
	logic is_long;
	logic is_memb;
	logic [3:0] memref_b_opcode_field;
	logic [1:0] an_l;
	logic [31:0] prod;
	logic [31:0] shift_full;
	logic mb_hit;
	acmsd_op_t ex_op;
	logic [15:0] ex_a;
	logic [15:0] ex_b;
	logic [2:0] ex_dst;
	logic ex_acc_we;
	logic ex_flag_we;
	logic ex_ph_we;
	logic [15:0] ex_ph;
	logic ex_mr_we;
	logic [15:0] ex_mr;
	logic ex_um_clr;
	logic [15:0] alu_res;
	acmsd_flags_t alu_flags;
	logic apb_wr;
	logic addr_ok;
	logic [31:0] rd_val;
	logic [2:0] ctrl_val;

	default clocking acmsd_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	assign is_short = (instr_word[16:13] == `ACMSD_SHORT_TAG);
	assign is_long = (instr_word[16:12] == `ACMSD_LONG_TAG)
		&& (instr_word[4:2] == `ACMSD_LONG_SUB);
	assign is_memb = (instr_word[16:15] == `ACMSD_MEMB_TAG);
	assign memref_b_opcode_field = instr_word[14:11];

	// no stall while a word is expected; string fetch owns the cycle
	assign instr_ready = (st_q == ACMSD_ST_IDLE)
		|| (st_q == ACMSD_ST_CONST);
	assign take = instr_valid && instr_ready;
	assign take_op = take && (st_q == ACMSD_ST_IDLE);
	assign take_k = take && (st_q == ACMSD_ST_CONST);
	assign an_l = 2'(op_word_q[9:8] + str_k_q);

	// operands are sign-extended only in signed multiply mode
	assign prod = {{16{~unsigned_multiply_mode_q & multiplier_operand_reg_q[15]}},
		multiplier_operand_reg_q}
		* {{16{~unsigned_multiply_mode_q & mem_operand[15]}}, mem_operand};
	// zero fill right, sign or zero fill left
	assign shift_full = {{16{sign_extend_mode_q & mem_operand[15]}},
		mem_operand} << shift_value_reg_q;

	always_comb begin
		mb_hit = 1'b0;
		ex_op = ACMSD_OP_ADD;
		ex_a = 16'h0000;
		ex_b = 16'h0000;
		ex_dst = 3'h0;
		ex_acc_we = 1'b0;
		ex_flag_we = 1'b0;
		ex_ph_we = 1'b0;
		ex_ph = 16'h0000;
		ex_mr_we = 1'b0;
		ex_mr = 16'h0000;
		ex_um_clr = 1'b0;
		if (take_op && is_memb) begin
			ex_dst = {1'b0, instr_word[9:8]};
			ex_a = acc_q[ex_dst];
			mb_hit = 1'b1;
			case (memref_b_opcode_field)
			`ACMSD_OP_MUL_ADD: begin
				ex_b = prod[15:0];
				ex_ph = prod[31:16];
			end
			`ACMSD_OP_MUL_SUB: begin
				ex_op = ACMSD_OP_SUB;
				ex_b = prod[15:0];
				ex_ph = prod[31:16];
			end
			`ACMSD_OP_SHLT: begin
				ex_op = ACMSD_OP_LOAD;
				ex_b = shift_full[15:0];
				ex_ph = shift_full[31:16];
			end
			`ACMSD_OP_SHLS: begin
				ex_op = ACMSD_OP_SUB;
				ex_b = shift_full[15:0];
				ex_ph = shift_full[31:16];
			end
			`ACMSD_OP_SHLA: begin
				ex_b = shift_full[15:0];
				ex_ph = shift_full[31:16];
			end
			default: mb_hit = 1'b0;
			endcase
			ex_acc_we = mb_hit;
			ex_flag_we = mb_hit;
			ex_ph_we = mb_hit;
		end else if (take_op && is_short) begin
			// immediate held in the opcode word
			ex_dst = {1'b0, instr_word[9:8]};
			ex_a = acc_q[ex_dst];
			ex_b = {8'h00, instr_word[7:0]};
			ex_op = acmsd_op_t'(instr_word[12:10]);
			if (ex_op == ACMSD_OP_LDMUL) begin
				// top byte zeroed, mode and status kept
				ex_mr_we = 1'b1;
				ex_mr = ex_b;
			end else begin
				ex_acc_we = (ex_op != ACMSD_OP_CMP);
				ex_flag_we = 1'b1;
			end
		end else if ((take_k && !string_mode_q)
			|| (st_q == ACMSD_ST_STRING)) begin
			// string words come from the fetch port
			ex_b = (st_q == ACMSD_ST_STRING) ? pm_rdata : instr_word[15:0];
			ex_a = acc_q[{op_word_q[1], an_l}];
			ex_dst = {op_word_q[0], an_l};
			ex_op = acmsd_op_t'(op_word_q[7:5]);
			if (ex_op == ACMSD_OP_LDMUL) begin
				ex_mr_we = 1'b1;
				ex_mr = ex_b;
				ex_um_clr = 1'b1;
			end else begin
				ex_acc_we = (ex_op != ACMSD_OP_CMP);
				ex_flag_we = 1'b1;
			end
		end
	end

	acmsd_alu u_alu (
		.op(ex_op),
		.a(ex_a),
		.b(ex_b),
		.res(alu_res),
		.flags(alu_flags)
	);

	// short ops finish in the accept cycle
	// long ops take opcode then constant
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ACMSD_ST_IDLE;
		end else begin
			case (st_q)
			ACMSD_ST_IDLE: begin
				if (take && is_long) begin
					st_q <= ACMSD_ST_CONST;
				end
			end
			ACMSD_ST_CONST: begin
				if (take) begin
					st_q <= string_mode_q ? ACMSD_ST_STRING : ACMSD_ST_IDLE;
				end
			end
			ACMSD_ST_STRING: begin
				if (str_left_q == 8'h01) begin
					st_q <= ACMSD_ST_IDLE;
				end
			end
			default: st_q <= ACMSD_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_word_q <= 17'h00000;
		end else if (take_op && is_long) begin
			op_word_q <= instr_word;
		end
	end

	// one fetch per string word; a zero count still fetches one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			str_left_q <= 8'h00;
			str_k_q <= 2'h0;
			pm_addr_q <= `ACMSD_RST_WORD;
		end else if (take_k && string_mode_q) begin
			str_left_q <= (string_count_q == 8'h00) ? 8'h01 : string_count_q;
			str_k_q <= 2'h0;
			pm_addr_q <= instr_word[15:0];
		end else if (st_q == ACMSD_ST_STRING) begin
			str_left_q <= 8'(str_left_q - 8'h01);
			str_k_q <= (str_left_q == 8'h01) ? 2'h0 : 2'(str_k_q + 2'h1);
			pm_addr_q <= 16'(pm_addr_q + 16'h0001);
		end
	end
	assign pm_rd = (st_q == ACMSD_ST_STRING);
	assign pm_addr = pm_addr_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				acc_q[i] <= `ACMSD_RST_WORD;
			end
		end else if (ex_acc_we) begin
			acc_q[ex_dst] <= alu_res;
		end else if (apb_wr && paddr[7:5] == `ACMSD_ACC_BANK) begin
			acc_q[paddr[4:2]] <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= '0;
		end else if (ex_flag_we) begin
			flags_q <= alu_flags;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			product_high_reg_q <= `ACMSD_RST_WORD;
		end else if (ex_ph_we) begin
			product_high_reg_q <= ex_ph;
		end
	end

	// instruction writes win over a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			multiplier_operand_reg_q <= `ACMSD_RST_WORD;
		end else if (ex_mr_we) begin
			multiplier_operand_reg_q <= ex_mr;
		end else if (apb_wr && paddr == `ACMSD_ADDR_MULT_OPND) begin
			multiplier_operand_reg_q <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sign_extend_mode_q <= 1'b0;
			unsigned_multiply_mode_q <= 1'b0;
			string_mode_q <= 1'b0;
			shift_value_reg_q <= 4'h0;
			string_count_q <= `ACMSD_RST_SCNT;
		end else begin
			if (apb_wr && paddr == `ACMSD_ADDR_CTRL) begin
				sign_extend_mode_q <= pwdata[`ACMSD_CTRL_SXM];
				unsigned_multiply_mode_q <= pwdata[`ACMSD_CTRL_UNS];
				string_mode_q <= pwdata[`ACMSD_CTRL_STR];
			end
			if (ex_um_clr) begin
				unsigned_multiply_mode_q <= 1'b0;
			end
			if (apb_wr && paddr == `ACMSD_ADDR_SHIFT_CNT) begin
				shift_value_reg_q <= pwdata[3:0];
			end
			if (apb_wr && paddr == `ACMSD_ADDR_SCNT) begin
				string_count_q <= pwdata[7:0];
			end
		end
	end

	// zero-wait apb slave; read data is captured in the setup cycle
	assign pready = 1'b1;
	assign apb_wr = psel && penable && pwrite && addr_ok;
	assign pslverr = psel && penable && !addr_ok;
	always_comb begin
		ctrl_val = 3'h0;
		ctrl_val[`ACMSD_CTRL_SXM] = sign_extend_mode_q;
		ctrl_val[`ACMSD_CTRL_UNS] = unsigned_multiply_mode_q;
		ctrl_val[`ACMSD_CTRL_STR] = string_mode_q;
		addr_ok = 1'b1;
		rd_val = 32'h00000000;
		case (paddr)
		`ACMSD_ADDR_CTRL: rd_val = {29'h0, ctrl_val};
		`ACMSD_ADDR_MULT_OPND: rd_val = {16'h0000, multiplier_operand_reg_q};
		`ACMSD_ADDR_SHIFT_CNT: rd_val = {28'h0, shift_value_reg_q};
		`ACMSD_ADDR_PROD_HI: rd_val = {16'h0000, product_high_reg_q};
		`ACMSD_ADDR_STAT: rd_val = {28'h0, st_q != ACMSD_ST_IDLE, flags_q};
		`ACMSD_ADDR_SCNT: rd_val = {24'h0, string_count_q};
		default: begin
			addr_ok = (paddr[7:5] == `ACMSD_ACC_BANK) && (paddr[1:0] == 2'h0);
			rd_val = addr_ok ? {16'h0000, acc_q[paddr[4:2]]} : 32'h00000000;
		end
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata_q <= rd_val;
		end
	end
	assign prdata = prdata_q;

	AST_MUL_ADD: assert property (
		(take_op && is_memb && memref_b_opcode_field == `ACMSD_OP_MUL_ADD) |=>
		acc_q[$past(ex_dst)] == $past(16'(acc_q[ex_dst] + prod[15:0]))
		&& product_high_reg_q == $past(prod[31:16]))
		else $error("multiply-add result wrong");
	AST_MUL_SUB: assert property (
		(take_op && is_memb && memref_b_opcode_field == `ACMSD_OP_MUL_SUB) |=>
		acc_q[$past(ex_dst)] == $past(16'(acc_q[ex_dst] - prod[15:0]))
		&& product_high_reg_q == $past(prod[31:16]))
		else $error("multiply-subtract result wrong");
	AST_SHIFT_XFER: assert property (
		(take_op && is_memb && memref_b_opcode_field == `ACMSD_OP_SHLT) |=>
		{product_high_reg_q, acc_q[$past(ex_dst)]} == $past(shift_full))
		else $error("shift transfer result wrong");
	AST_SHIFT_FILL: assert property (
		(take_op && is_memb && memref_b_opcode_field == `ACMSD_OP_SHLT
		&& !sign_extend_mode_q && shift_value_reg_q != 4'h0) |=>
		!product_high_reg_q[15] && !acc_q[$past(ex_dst)][0])
		else $error("shift fill wrong");
	AST_SHIFT_ADD: assert property (
		(take_op && is_memb && memref_b_opcode_field == `ACMSD_OP_SHLA) |=>
		acc_q[$past(ex_dst)] == $past(16'(acc_q[ex_dst] + shift_full[15:0])))
		else $error("shift-add result wrong");
	AST_SHIFT_SUB: assert property (
		(take_op && is_memb && memref_b_opcode_field == `ACMSD_OP_SHLS) |=>
		acc_q[$past(ex_dst)] == $past(16'(acc_q[ex_dst] - shift_full[15:0]))
		&& product_high_reg_q == $past(shift_full[31:16]))
		else $error("shift-subtract result wrong");
	AST_SHORT_ONE: assert property (
		(take_op && is_short) |=> st_q == ACMSD_ST_IDLE && instr_ready)
		else $error("short op not done in one cycle");
	AST_SHORT_LOAD: assert property (
		(take_op && is_short && instr_word[12:10] == 3'h1) |=>
		acc_q[$past(ex_dst)] == {8'h00, $past(instr_word[7:0])}
		&& flags_q.zf == ($past(instr_word[7:0]) == 8'h00))
		else $error("short load wrong");
	AST_SHORT_CMP: assert property (
		(take_op && is_short && instr_word[12:10] == 3'h3) |=>
		acc_q[$past(ex_dst)] == $past(acc_q[ex_dst])
		&& flags_q.zf == $past(acc_q[ex_dst] == ex_b))
		else $error("short compare wrong");
	AST_SHORT_MR: assert property (
		(take_op && is_short && instr_word[12:10] == 3'h7) |=>
		multiplier_operand_reg_q == {8'h00, $past(instr_word[7:0])}
		&& $stable(unsigned_multiply_mode_q) && $stable(flags_q))
		else $error("short multiplier load wrong");
	AST_LONG_TWO: assert property (
		(take_op && is_long) |=> st_q == ACMSD_ST_CONST)
		else $error("long op did not wait for constant");
	AST_LONG_CMP: assert property (
		(take_k && !string_mode_q && op_word_q[7:5] == 3'h3) |=>
		acc_q[$past(ex_dst)] == $past(acc_q[ex_dst]))
		else $error("long compare wrote accumulator");
	AST_LONG_MR: assert property (
		(take_k && !string_mode_q && op_word_q[7:5] == 3'h7) |=>
		multiplier_operand_reg_q == $past(instr_word[15:0])
		&& !unsigned_multiply_mode_q && $stable(flags_q))
		else $error("long multiplier load wrong");
	AST_STR_END: assert property (
		(st_q == ACMSD_ST_STRING && str_left_q == 8'h01) |=>
		st_q == ACMSD_ST_IDLE)
		else $error("string fetch did not end");
endmodule // acmsd_decode
`default_nettype wire

// ===== hw/acmsd_cfg.svh
// offsets, field positions, reset values and opcode encodings of the decoder
//
// Contract
// - multiply-add: acc plus product low, high latched
// - multiply-subtract: acc minus product low, high latched
// - shift-transfer: shifted low to acc, high latched
// - shift fills zeros right, sign or zeros left
// - shift-subtract: acc minus shifted low, high latched
// - shift-add: acc plus shifted low, high latched
// - short form combines acc with 8-bit immediate
// - short form: one word, one cycle
// - short op codes 000..110, immediate zero-extended
// - short compare sets status, keeps accumulator
// - short 111 loads multiplier operand, zero top
// - long form: two words, two cycles
// - non-string long constant is second word
// - string constant via pointer, count plus two cycles; a zero count still fetches one word and takes three
// - long op codes, source and destination select
// - long compare sets status, writes no accumulator
// - long 111 loads multiplier operand, signed, status kept
// - destination bit: zero accumulator, one offset
`ifndef ACMSD_CFG_SVH
`define ACMSD_CFG_SVH
`define ACMSD_ADDR_CTRL 8'h00
`define ACMSD_ADDR_MULT_OPND 8'h04
`define ACMSD_ADDR_SHIFT_CNT 8'h08
`define ACMSD_ADDR_PROD_HI 8'h0C
`define ACMSD_ADDR_STAT 8'h10
`define ACMSD_ADDR_SCNT 8'h14
`define ACMSD_ACC_BANK 3'h1
`define ACMSD_CTRL_SXM 0
`define ACMSD_CTRL_UNS 1
`define ACMSD_CTRL_STR 2
`define ACMSD_RST_WORD 16'h0000
`define ACMSD_RST_SCNT 8'h00
`define ACMSD_SHORT_TAG 4'hA
`define ACMSD_LONG_TAG 5'h1C
`define ACMSD_LONG_SUB 3'h1
`define ACMSD_MEMB_TAG 2'h1
`define ACMSD_OP_MUL_ADD 4'hB
`define ACMSD_OP_SHLT 4'hC
`define ACMSD_OP_SHLS 4'hD
`define ACMSD_OP_SHLA 4'hE
`define ACMSD_OP_MUL_SUB 4'hF
`endif

// ===== hw/acmsd_pkg.sv
// types shared by the decoder and its alu
package acmsd_pkg;
	typedef enum logic [2:0] {
		ACMSD_OP_ADD = 3'h0,
		ACMSD_OP_LOAD = 3'h1,
		ACMSD_OP_SUB = 3'h2,
		ACMSD_OP_CMP = 3'h3,
		ACMSD_OP_OR = 3'h4,
		ACMSD_OP_AND = 3'h5,
		ACMSD_OP_XOR = 3'h6,
		ACMSD_OP_LDMUL = 3'h7
	} acmsd_op_t;
	typedef enum logic [2:0] {
		ACMSD_ST_IDLE = 3'h1,
		ACMSD_ST_CONST = 3'h2,
		ACMSD_ST_STRING = 3'h4
	} acmsd_state_t;
	typedef struct packed {
		logic zf;
		logic sf;
		logic cf;
	} acmsd_flags_t;
endpackage

// ===== hw/acmsd_alu.sv
// 16-bit accumulator alu with status outputs
`timescale 1ns/1ps
`default_nettype none
module acmsd_alu (
	input wire acmsd_pkg::acmsd_op_t op,
	input wire logic [15:0] a,
	input wire logic [15:0] b,
	output logic [15:0] res,
	output var acmsd_pkg::acmsd_flags_t flags
);
	import acmsd_pkg::*;
	logic [16:0] sum;
	always_comb begin
		sum = 17'h00000;
		res = a;
		case (op)
		ACMSD_OP_ADD: begin
			sum = {1'b0, a} + {1'b0, b};
			res = sum[15:0];
		end
		ACMSD_OP_SUB, ACMSD_OP_CMP: begin
			// carry set means no borrow
			sum = {1'b0, a} + {1'b0, ~b} + 17'h00001;
			res = sum[15:0];
		end
		ACMSD_OP_LOAD: res = b;
		ACMSD_OP_OR: res = a | b;
		ACMSD_OP_AND: res = a & b;
		ACMSD_OP_XOR: res = a ^ b;
		default: res = a;
		endcase
	end
	// compare reports the difference; the caller suppresses the write
	assign flags.zf = (res == 16'h0000);
	assign flags.sf = res[15];
	assign flags.cf = sum[16];
endmodule // acmsd_alu
`default_nettype wire

// ===== sim/acmsd_pm_model.sv
// program memory model answering string constant fetches
`timescale 1ns/1ps
`default_nettype none
module acmsd_pm_model (
	input wire logic pclk,
	input wire logic pm_rd,
	input wire logic [15:0] pm_addr,
	output logic [15:0] pm_rdata
);
	logic [15:0] last_q = 16'h3C3C;
	// asynchronous read; an idle bus toggles so stale data never matches
	always_comb begin
		if (pm_rd) begin
			pm_rdata = (pm_addr * 16'h9E37) ^ 16'h5A5A;
		end else begin
			pm_rdata = ~last_q;
		end
	end
	always_ff @(posedge pclk) begin
		last_q <= pm_rdata;
	end
endmodule // acmsd_pm_model
`default_nettype wire

// ===== sim/tb_accum_const_mul_shift_decode.sv
// self-checking bench for the constant and multiply/shift decoder
`timescale 1ns/1ps
`default_nettype none
module tb_accum_const_mul_shift_decode;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, instr_valid = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, st, stm, p;
	logic pready, pslverr, instr_ready, pm_rd;
	logic [16:0] instr_word = 17'h0;
	logic [15:0] mem_operand = 16'h0, pm_addr, pm_rdata, mop, m16, pw;
	logic [15:0] acc[8];
	logic [64:0] exp_q[$];
	logic [64:0] ent;
	logic [17:0] r;
	logic [3:0] o;
	integer miscompares = 0, n_checks = 0, seed = 65093, i, k, n, d;
	always #5 pclk = ~pclk;
	acmsd_decode dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instr_valid(instr_valid), .instr_word(instr_word),
		.instr_ready(instr_ready), .mem_operand(mem_operand),
		.pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata));
	acmsd_pm_model pm (.pclk(pclk), .pm_rd(pm_rd), .pm_addr(pm_addr),
		.pm_rdata(pm_rdata));
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int j;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		j = 0;
		do begin
			@(posedge pclk);
			j++;
		end while (!pready && j < 20);
		if (!pready) begin
			miscompares++;
			end_of_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m, input logic err);
		exp_q.push_back({err, m, e & m});
		apb(1'b0, a, 32'h0);
	endtask
	// read results are matched against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready) begin
			ent = exp_q.pop_front();
			chk({31'h0, ent[64]}, {31'h0, pslverr});
			chk(ent[31:0], prdata & ent[63:32]);
		end
	end
	task automatic issue(input logic [16:0] w, input logic [15:0] m, input bit last);
		instr_valid <= 1'b1;
		instr_word <= w;
		mem_operand <= m;
		@(posedge pclk);
		if (last) instr_valid <= 1'b0;
	endtask
	function automatic logic [7:0] aa(input int x);
		return 8'(32 + 4 * x);
	endfunction
	// carry is only defined for add, subtract and compare
	function automatic logic [17:0] alu(input logic [2:0] op,
		input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		case (op)
			3'h0: s = {1'b0, a} + {1'b0, b};
			3'h2, 3'h3: s = ({1'b0, a} - {1'b0, b}) ^ 17'h10000;
			3'h4: s = {1'b0, a | b};
			3'h5: s = {1'b0, a & b};
			3'h6: s = {1'b0, a ^ b};
			default: s = {1'b0, b};
		endcase
		return {op == 3'h0 || op[2:1] == 2'h1, s};
	endfunction
	task automatic set_st(input logic [17:0] v);
		st = {29'h0, v[15:0] == 16'h0, v[15], v[16]};
		stm = v[17] ? ALL : 32'hFFFFFFFE;
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, ALL, 1'b0);
		wr(8'h1C, 32'h5);
		rd(8'h1C, 32'h0, ALL, 1'b1);
		st = 32'h0;
		stm = ALL;
		mop = 16'h0;
		for (i = 0; i < 8; i++) begin
			acc[i] = 16'($random(seed));
			wr(aa(i), {16'h0, acc[i]});
		end
		for (i = 0; i < 16; i++) begin
			k = $random(seed) & 3;
			n = $random(seed) & 255;
			for (int t = 0; t < 2; t++) begin
				issue({4'hA, 3'(i), 2'(k), 8'(n)}, 16'h0, t == 1);
				r = alu(3'(i), acc[k], 16'(n));
				if (i % 8 == 7) begin
					mop = 16'(n);
				end else begin
					set_st(r);
					if (i % 8 != 3) acc[k] = r[15:0];
				end
			end
			rd(aa(k), {16'h0, acc[k]}, ALL, 1'b0);
			rd(8'h10, st, stm, 1'b0);
			rd(8'h04, {16'h0, mop}, ALL, 1'b0);
		end
		for (i = 0; i < 16; i++) begin
			k = $random(seed) & 15;
			m16 = 16'($random(seed));
			wr(8'h00, 32'h2);
			issue({5'h1C, 2'h0, 2'(k), 3'(i), 3'h1, k[2], k[3]}, 16'h0, 1'b0);
			issue({1'b0, m16}, 16'h0, 1'b1);
			r = alu(3'(i), acc[4 * k[2] + k % 4], m16);
			d = 4 * k[3] + k % 4;
			if (i % 8 == 7) begin
				mop = m16;
			end else begin
				set_st(r);
				if (i % 8 != 3) acc[d] = r[15:0];
			end
			rd(aa(d), {16'h0, acc[d]}, ALL, 1'b0);
			rd(8'h10, st, stm, 1'b0);
			rd(8'h04, {16'h0, mop}, ALL, 1'b0);
			rd(8'h00, (i % 8 == 7) ? 32'h0 : 32'h2, ALL, 1'b0);
		end
		for (i = 0; i < 10; i++) begin
			o = 4'(11 + i % 5);
			k = $random(seed) & 3;
			m16 = 16'($random(seed));
			mop = 16'($random(seed));
			n = $random(seed);
			wr(8'h04, {16'h0, mop});
			wr(8'h08, {28'h0, 4'(n)});
			wr(8'h00, {30'h0, 2'(n >> 4)});
			issue({2'h1, o, 1'b0, 2'(k), 8'h00}, m16, 1'b1);
			if (o == 4'hB || o == 4'hF) begin
				if (n[5]) p = {16'h0, mop} * {16'h0, m16};
				else p = $signed(mop) * $signed(m16);
			end else begin
				p = (n[4] ? {{16{m16[15]}}, m16} : {16'h0, m16}) << n[3:0];
			end
			r = alu((o == 4'hD || o == 4'hF) ? 3'h2 :
				(o == 4'hC ? 3'h1 : 3'h0), acc[k], p[15:0]);
			acc[k] = r[15:0];
			set_st(r);
			rd(aa(k), {16'h0, acc[k]}, ALL, 1'b0);
			rd(8'h0C, {16'h0, p[31:16]}, ALL, 1'b0);
			rd(8'h10, st, stm, 1'b0);
		end
		wr(8'h00, 32'h4);
		wr(8'h14, 32'h3);
		m16 = 16'($random(seed));
		issue({5'h1C, 2'h0, 2'h3, 3'h0, 3'h1, 1'b0, 1'b1}, 16'h0, 1'b0);
		issue({1'b0, m16}, 16'h0, 1'b1);
		n = 0;
		while (n < 40) begin
			@(negedge pclk);
			if (instr_ready) break;
			n++;
		end
		@(posedge pclk);
		chk(32'h3, 32'(n));
		for (k = 0; k < 3; k++) begin
			d = (3 + k) % 4;
			pw = 16'(m16 + k);
			acc[4 + d] = acc[d] + ((pw * 16'h9E37) ^ 16'h5A5A);
		end
		for (d = 4; d < 8; d++) rd(aa(d), {16'h0, acc[d]}, ALL, 1'b0);
		end_of_test();
	end
endmodule // tb_accum_const_mul_shift_decode
`default_nettype wire
